// ---- verilog/dmem_cfg.svh ----
// Constants for the data memory access block: offsets, reset values,
// memory limits and timing counts.
// Assumes it is included by bare name from files that need the numbers.
`ifndef DMEM_CFG_SVH
`define DMEM_CFG_SVH

// ----------------------------------------------------------------------
// Special-function register offsets
// ----------------------------------------------------------------------
`define IND_FIRST_OFS 8'h00
`define PTR_FIRST_OFS 8'h01
`define IND_SECOND_OFS 8'h02
`define PTR_SECOND_OFS 8'h03
`define BANK_SEL_OFS 8'h04
`define TBL_HIGH_OFS 8'h08
`define NVM_CTRL_OFS 8'h40

// ----------------------------------------------------------------------
// Reset values and field masks
// ----------------------------------------------------------------------
`define PTR_RST 8'h00
`define BANK_SEL_RST 8'h00
`define BANK_SEL_MASK 8'h01
`define NVM_CTRL_RST 8'h00
`define ZERO_BYTE 8'h00

// ----------------------------------------------------------------------
// Memory limits
// ----------------------------------------------------------------------
`define GP_BANK0_LO 8'h60
`define GP_BANK1_LO 8'h80
`define GP_BANK0_WORDS 160
`define GP_BANK1_WORDS 128
`define PM_WORDS 2048
`define PM_ADDR_W 11
`define PM_WORD_W 16
`define PM_LAST_PAGE 11'h700
`define TBL_HIGH_MASK 8'hff

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define TBL_CYCLES 2
`define ICP_WORD_BITS 5'h10
`define ICP_BIT_ZERO 5'h00

`endif

// ---- verilog/dmem_pkg.sv ----
// Types shared by the data memory access block.
// Assumes nothing beyond the constants header.
`default_nettype none

package dmem_pkg;
   typedef enum logic [1:0] {TBL_IDLE, TBL_FETCH} tbl_state_t;
   typedef logic [7:0] byte_t;
endpackage

`default_nettype wire

// ---- verilog/ram_bus_if.sv ----
// Carrier between the access decoder and the general-purpose RAM.
// Assumes both ends share the system clock.
`default_nettype none

interface ram_bus_if;
   logic bank;
   logic [7:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hit;
   modport ctrl (output bank, output addr, output we, output wdata,
                 input rdata, input hit);
   modport mem (input bank, input addr, input we, input wdata,
                output rdata, output hit);
endinterface

`default_nettype wire

// ---- verilog/gp_ram.sv ----
// General-purpose RAM of both data banks, read combinationally.
// Assumes the decoder asserts we for one cycle per write.
`default_nettype none
`include "dmem_cfg.svh"

module gp_ram
   import dmem_pkg::*;
#(
   parameter bit HAS_BANK1 = 1'b1
)
(
   input wire logic clk,
   ram_bus_if.mem bus
);
   // No reset: the RAM is volatile and holds garbage after power-up
   logic [7:0] bank0_mem [0:`GP_BANK0_WORDS-1];
   logic [7:0] bank1_mem [0:`GP_BANK1_WORDS-1];

   wire logic hit0 = !bus.bank && (bus.addr >= `GP_BANK0_LO);
   wire logic hit1 = HAS_BANK1 && bus.bank &&
                     (bus.addr >= `GP_BANK1_LO);
   wire logic [7:0] idx0 = bus.addr - `GP_BANK0_LO;
   wire logic [6:0] idx1 = bus.addr[6:0];

   assign bus.hit = hit0 || hit1;
   assign bus.rdata = hit0 ? bank0_mem[idx0] :
                      hit1 ? bank1_mem[idx1] : `ZERO_BYTE;

   always_ff @(posedge clk)
   begin
      if (bus.we && hit0)
         bank0_mem[idx0] <= bus.wdata;
      if (bus.we && hit1)
         bank1_mem[idx1] <= bus.wdata;
   end
endmodule // gp_ram

`default_nettype wire

// ---- verilog/table_reader.sv ----
// Two-cycle table read sequencer with the table high-byte latch.
// Assumes program memory answers pm_rdata in the cycle pm_rd is high.
`default_nettype none
`include "dmem_cfg.svh"

module table_reader
   import dmem_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic last_page,
   input wire logic [7:0] ptr_low,
   input wire logic [2:0] ptr_high,
   input wire logic [`PM_WORD_W-1:0] pm_rdata,
   output logic [`PM_ADDR_W-1:0] pm_addr_r,
   output logic pm_rd_r,
   output logic [`PM_WORD_W-1:0] word_r,
   output logic done_r
);
   tbl_state_t state_r;
   tbl_state_t state_nxt;

   // Last-page reads force the top address bits onto the final page
   wire logic [`PM_ADDR_W-1:0] addr_nxt = last_page ?
      (`PM_LAST_PAGE | {3'h0, ptr_low}) : {ptr_high, ptr_low};
   wire logic take = (state_r == TBL_IDLE) && start;

   always_comb
   begin
      case (state_r)
         TBL_IDLE: state_nxt = start ? TBL_FETCH : TBL_IDLE;
         TBL_FETCH: state_nxt = TBL_IDLE;
         default: state_nxt = TBL_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= TBL_IDLE;
         pm_addr_r <= '0;
         pm_rd_r <= 1'b0;
         word_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         pm_rd_r <= take;
         done_r <= (state_r == TBL_FETCH);
         if (take)
            pm_addr_r <= addr_nxt;
         // Overwrites the previous word; nothing can restore it
         if (state_r == TBL_FETCH)
            word_r <= pm_rdata;
      end
   end
endmodule // table_reader

`default_nettype wire

// ---- verilog/dmem_access.sv ----
// Data memory access unit: bank select, indirect ports, table latch,
// control register and the serial programming receiver.
// Assumes the execution core drives requests on the same clock.
`default_nettype none
`include "dmem_cfg.svh"

module dmem_access
   import dmem_pkg::*;
#(
   parameter bit HAS_BANK1 = 1'b1
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] acc_addr,
   input wire logic acc_rd,
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata_r,
   output logic acc_rvalid_r,
   input wire logic tbl_start,
   input wire logic tbl_last_page,
   input wire logic [7:0] tbl_ptr_low,
   input wire logic [2:0] tbl_ptr_high,
   input wire logic [`PM_WORD_W-1:0] pm_rdata,
   output logic [`PM_ADDR_W-1:0] pm_addr_r,
   output logic pm_rd_r,
   output logic [`PM_WORD_W-1:0] tbl_word_r,
   output logic tbl_done_r,
   output logic [7:0] nvm_ctrl_r,
   input wire logic prog_mode,
   input wire logic programming_data_line_in,
   output logic programming_data_line_out,
   output logic programming_data_line_oe,
   input wire logic programming_clock_line_in,
   output logic [`PM_ADDR_W-1:0] icp_addr_r,
   output logic [`PM_WORD_W-1:0] icp_wdata_r,
   output logic icp_wr_r
);
   // -------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------
   function automatic logic is_port(input logic [7:0] a);
      is_port = (a == `IND_FIRST_OFS) || (a == `IND_SECOND_OFS);
   endfunction

   byte_t ptr_first_r;
   byte_t ptr_second_r;
   byte_t bank_sel_r;
   ram_bus_if ram_if ();

   wire logic via_first = (acc_addr == `IND_FIRST_OFS);
   wire logic via_second = (acc_addr == `IND_SECOND_OFS);
   wire logic via_port = via_first || via_second;
   wire byte_t eff_addr = via_first ? ptr_first_r :
                          via_second ? ptr_second_r : acc_addr;
   // First pair is fixed to bank 0, second follows the bank pointer
   wire logic eff_bank = via_first ? 1'b0 : bank_sel_r[0];
   wire logic self_hit = via_port && is_port(eff_addr);
   wire logic sel_ptr_first = !self_hit && (eff_addr == `PTR_FIRST_OFS);
   wire logic sel_ptr_second = !self_hit && (eff_addr == `PTR_SECOND_OFS);
   wire logic sel_bank = !self_hit && (eff_addr == `BANK_SEL_OFS);
   wire logic sel_tbl = !self_hit && (eff_addr == `TBL_HIGH_OFS);
   wire logic sel_nvm = !self_hit && eff_bank &&
                        (eff_addr == `NVM_CTRL_OFS);
   wire byte_t tbl_high = tbl_word_r[15:8] & `TBL_HIGH_MASK;

   // -------------------------------------------------------------------
   // General RAM
   // -------------------------------------------------------------------
   assign ram_if.bank = eff_bank;
   assign ram_if.addr = eff_addr;
   assign ram_if.we = acc_wr && !self_hit;
   assign ram_if.wdata = acc_wdata;

   gp_ram #(.HAS_BANK1(HAS_BANK1)) u_ram (
      .clk(clk),
      .bus(ram_if.mem)
   );

   // Registers not held here (accumulator, ports, timers) read as zero
   wire byte_t rd_mux = self_hit ? `ZERO_BYTE :
                        sel_ptr_first ? ptr_first_r :
                        sel_ptr_second ? ptr_second_r :
                        sel_bank ? bank_sel_r :
                        sel_tbl ? tbl_high :
                        sel_nvm ? nvm_ctrl_r :
                        ram_if.hit ? ram_if.rdata : `ZERO_BYTE;

   // -------------------------------------------------------------------
   // Special-function registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ptr_first_r <= `PTR_RST;
         ptr_second_r <= `PTR_RST;
         bank_sel_r <= `BANK_SEL_RST;
         nvm_ctrl_r <= `NVM_CTRL_RST;
         acc_rdata_r <= `ZERO_BYTE;
         acc_rvalid_r <= 1'b0;
      end
      else
      begin
         acc_rvalid_r <= acc_rd;
         if (acc_rd)
            acc_rdata_r <= rd_mux;
         if (acc_wr && sel_ptr_first)
            ptr_first_r <= acc_wdata;
         if (acc_wr && sel_ptr_second)
            ptr_second_r <= acc_wdata;
         if (acc_wr && sel_bank)
            bank_sel_r <= acc_wdata & `BANK_SEL_MASK;
         if (acc_wr && sel_nvm)
            nvm_ctrl_r <= acc_wdata;
      end
   end

   // -------------------------------------------------------------------
   // Table read path
   // -------------------------------------------------------------------
   // The latch has no write path at all, so a write at its offset is lost
   table_reader u_tbl (
      .clk(clk),
      .resetn(resetn),
      .start(tbl_start),
      .last_page(tbl_last_page),
      .ptr_low(tbl_ptr_low),
      .ptr_high(tbl_ptr_high),
      .pm_rdata(pm_rdata),
      .pm_addr_r(pm_addr_r),
      .pm_rd_r(pm_rd_r),
      .word_r(tbl_word_r),
      .done_r(tbl_done_r)
   );

   // -------------------------------------------------------------------
   // Serial programming receiver
   // -------------------------------------------------------------------
   // Download only; upload waits for a protocol definition, so the
   // data line is never driven and the board must keep it free
   logic pck_meta_r, pck_sync_r, pck_prev_r;
   logic pda_meta_r, pda_sync_r;
   logic [4:0] icp_bits_r;
   logic [`PM_WORD_W-1:0] icp_shift_r;
   wire logic pck_rise = pck_sync_r && !pck_prev_r;
   wire logic [`PM_WORD_W-1:0] shift_nxt =
      {icp_shift_r[`PM_WORD_W-2:0], pda_sync_r};
   wire logic word_full = (icp_bits_r == (`ICP_WORD_BITS - 5'h01));

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pck_meta_r <= 1'b0;
         pck_sync_r <= 1'b0;
         pck_prev_r <= 1'b0;
         pda_meta_r <= 1'b0;
         pda_sync_r <= 1'b0;
      end
      else
      begin
         pck_meta_r <= programming_clock_line_in;
         pck_sync_r <= pck_meta_r;
         pck_prev_r <= pck_sync_r;
         pda_meta_r <= programming_data_line_in;
         pda_sync_r <= pda_meta_r;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         icp_bits_r <= `ICP_BIT_ZERO;
         icp_shift_r <= '0;
         icp_addr_r <= '0;
         icp_wdata_r <= '0;
         icp_wr_r <= 1'b0;
         programming_data_line_out <= 1'b0;
         programming_data_line_oe <= 1'b0;
      end
      else
      begin
         icp_wr_r <= prog_mode && pck_rise && word_full;
         if (!prog_mode)
         begin
            icp_bits_r <= `ICP_BIT_ZERO;
            icp_addr_r <= '0;
         end
         else if (pck_rise)
         begin
            icp_shift_r <= shift_nxt;
            icp_bits_r <= word_full ? `ICP_BIT_ZERO : icp_bits_r + 5'h01;
            if (word_full)
               icp_wdata_r <= shift_nxt;
         end
         // A word finished as programming ends must not move the address
         if (icp_wr_r && prog_mode)
            icp_addr_r <= icp_addr_r + 11'h001;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence tbl_req;
      tbl_start && !pm_rd_r && !tbl_done_r ##0 !$past(tbl_start);
   endsequence
   sequence tbl_fetch;
      pm_rd_r && !tbl_done_r ##1 tbl_done_r;
   endsequence

   a_tbl_two_cycles: assert property (
      tbl_req |=> tbl_fetch)
      else $error("table read did not finish in two cycles");
   a_tbl_latch_load: assert property (
      pm_rd_r |=> tbl_done_r && tbl_high == $past(pm_rdata[15:8]))
      else $error("table latch missed program high byte");
   a_tbl_no_write: assert property (
      acc_wr && sel_tbl && !pm_rd_r |=> $stable(tbl_word_r))
      else $error("table latch changed on a write");
   a_last_page_addr: assert property (
      tbl_start && !pm_rd_r && tbl_last_page |=>
         pm_addr_r[10:8] == 3'h7 && pm_addr_r[7:0] == $past(tbl_ptr_low))
      else $error("last page table address wrong");
   a_first_pair_bank: assert property (
      via_first |-> !ram_if.bank && ram_if.addr == ptr_first_r)
      else $error("first indirect pair left bank 0");
   a_second_pair_bank: assert property (
      via_second |-> ram_if.bank == bank_sel_r[0] &&
         ram_if.addr == ptr_second_r)
      else $error("second indirect pair target wrong");
   a_self_read_zero: assert property (
      acc_rd && self_hit |=> acc_rvalid_r && acc_rdata_r == 8'h00)
      else $error("indirect self read not zero");
   a_nvm_bank0_blocked: assert property (
      acc_wr && !eff_bank && eff_addr == `NVM_CTRL_OFS |=>
         $stable(nvm_ctrl_r))
      else $error("control register written from bank 0");
   a_unmapped_zero: assert property (
      acc_rd && !ram_if.hit && !sel_ptr_first && !sel_ptr_second &&
         !sel_bank && !sel_tbl && !sel_nvm |=> acc_rdata_r == 8'h00)
      else $error("unmapped address did not read zero");
   a_bank_write: assert property (
      acc_wr && sel_bank |=> bank_sel_r == ($past(acc_wdata) & 8'h01))
      else $error("bank pointer not updated");
   a_read_answer: assert property (
      acc_rd |=> acc_rvalid_r)
      else $error("read answer missing");
   a_rdata_hold: assert property (
      !acc_rd |=> $stable(acc_rdata_r))
      else $error("read data changed without a read");
   a_port_read_target: assert property (
      acc_rd && via_port && ram_if.hit |=>
         acc_rdata_r == $past(ram_if.rdata))
      else $error("indirect read missed its target");
   a_self_write_none: assert property (
      acc_wr && self_hit |=> $stable(ptr_first_r) && $stable(ptr_second_r)
         && $stable(bank_sel_r) && $stable(nvm_ctrl_r))
      else $error("indirect self write changed a register");
   a_ptr_write: assert property (
      acc_wr && sel_ptr_second |=> ptr_second_r == $past(acc_wdata))
      else $error("second pointer not updated");
   a_nvm_bank1_write: assert property (
      acc_wr && sel_nvm |=> nvm_ctrl_r == $past(acc_wdata))
      else $error("control register write lost in bank 1");
   a_bank_bit_only: assert property (
      bank_sel_r[7:1] == 7'h00)
      else $error("bank pointer upper bits set");
   a_done_pulse: assert property (
      tbl_done_r |-> !pm_rd_r && $past(pm_rd_r))
      else $error("table done without a fetch");
   a_tbl_word_hold: assert property (
      !pm_rd_r |=> $stable(tbl_word_r))
      else $error("table word changed without a fetch");
   a_icp_addr_step: assert property (
      icp_wr_r && prog_mode |=> icp_addr_r == $past(icp_addr_r) + 11'h001)
      else $error("programming address did not step");
   a_icp_addr_clear: assert property (
      !prog_mode |=> icp_addr_r == 11'h000)
      else $error("programming address not cleared");
endmodule // dmem_access

`default_nettype wire

// ---- tb/pm_model.sv ----
// Program memory stand-in that answers the block's table fetches.
// Assumes fetch address and strobe come from the block on one clock.
`default_nettype none
`include "dmem_cfg.svh"

module pm_model
(
   input wire logic [`PM_ADDR_W-1:0] pm_addr,
   input wire logic pm_rd,
   output logic [`PM_WORD_W-1:0] pm_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [`PM_WORD_W-1:0] word;
   // 2K words, each derived from its own word address
   assign word = {pm_addr[7:0] ^ 8'h3c, pm_addr[10:8], pm_addr[4:0]};
   // Outside a fetch the bus shows the inverse, so stale data never matches
   assign pm_rdata = pm_rd ? word : ~word;
endmodule // pm_model

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the data memory access unit.
// Assumes the bench plays the execution core and the programming tool.
`default_nettype none
`include "dmem_cfg.svh"

module testbench
   import dmem_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   byte_t wdata = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic tstart = 1'b0;
   logic tlast = 1'b0;
   logic [7:0] tlo = 8'h00;
   logic [2:0] thi = 3'h0;
   logic pmode = 1'b0;
   logic pdi = 1'b0;
   logic pck = 1'b0;
   byte_t rdata;
   byte_t nvm;
   logic rvalid, pmr, tdone, oe, dout, icpw;
   logic [15:0] pmd, tword, icpd;
   logic [10:0] pma, icpa;
   logic [15:0] dq[$];
   logic [10:0] aq[$];
   logic [15:0] rnd = 16'h7503; // 29955
   int fails = 0;
   int checked = 0;
   int mem[512];
   int ptr0 = 0;
   int ptr1 = 0;
   int bank = 0;
   int latch_exp = 0;
   int nvmc = 0;

   always #12.5 clk = ~clk;

   dmem_access #(.HAS_BANK1(1'b1)) i_dmem_access (.clk(clk), .resetn(resetn),
      .acc_addr(addr), .acc_rd(rd), .acc_wr(wr), .acc_wdata(wdata),
      .acc_rdata_r(rdata), .acc_rvalid_r(rvalid), .tbl_start(tstart),
      .tbl_last_page(tlast), .tbl_ptr_low(tlo), .tbl_ptr_high(thi),
      .pm_rdata(pmd), .pm_addr_r(pma), .pm_rd_r(pmr), .tbl_word_r(tword),
      .tbl_done_r(tdone), .nvm_ctrl_r(nvm), .prog_mode(pmode),
      .programming_data_line_in(pdi), .programming_data_line_out(dout),
      .programming_data_line_oe(oe), .programming_clock_line_in(pck),
      .icp_addr_r(icpa), .icp_wdata_r(icpd), .icp_wr_r(icpw));

   pm_model i_pm_model (.pm_addr(pma), .pm_rd(pmr), .pm_rdata(pmd));

   always @(posedge clk)
      if (icpw === 1'b1)
      begin
         dq.push_back(icpd);
         aq.push_back(icpa);
      end

   // ---------------------------------------------------------------
   // Reference model of the data memory map
   // ---------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [15:0] pmw(input logic [10:0] a);
      return {a[7:0] ^ 8'h3c, a[10:8], a[4:0]};
   endfunction

   // Index of bank*256+offset, or -1 when a port points at a port
   function automatic int tgt(input int a);
      int t;
      t = (a == 0) ? ptr0 : (a == 2) ? bank * 256 + ptr1 : bank * 256 + a;
      if ((a == 0 || a == 2) && (t % 256 == 0 || t % 256 == 2))
         t = -1;
      return t;
   endfunction

   function automatic int mrd(input int t);
      int a;
      a = t % 256;
      if (t < 0 || a == 0 || a == 2)
         return 0;
      if (a == 1)
         return ptr0;
      if (a == 3)
         return ptr1;
      if (a == 4)
         return bank;
      if (a == 8)
         return latch_exp;
      if (a == 8'h40)
         return (t > 255) ? nvmc : 0;
      if ((a >= 8'h60 && t < 256) || a >= 8'h80)
         return mem[t];
      return 0;
   endfunction

   function automatic void mwr(input int t, input int d);
      int a;
      a = t % 256;
      if (t < 0)
         return;
      if (a == 1)
         ptr0 = d;
      else if (a == 3)
         ptr1 = d;
      else if (a == 4)
         bank = d % 2;
      else if (a == 8'h40 && t > 255)
         nvmc = d;
      else if ((a >= 8'h60 && t < 256) || a >= 8'h80)
         mem[t] = d;
   endfunction

   // ---------------------------------------------------------------
   // Shared bus tasks, entered at a falling edge
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      mwr(tgt(int'(a)), int'(d));
      @(negedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask

   task automatic rd_c(input logic [7:0] a);
      addr <= a;
      rd <= 1'b1;
      @(negedge clk);
      rd <= 1'b0;
      check({15'h0, rvalid}, 16'h0001);
      check({8'h00, rdata}, 16'(mrd(tgt(int'(a)))));
      @(negedge clk);
      check({15'h0, rvalid}, 16'h0000);
   endtask

   task automatic tbl_c(input logic last, input logic [10:0] p);
      logic [10:0] ea;
      logic [15:0] ew;
      ea = last ? (`PM_LAST_PAGE | {3'h0, p[7:0]}) : p;
      ew = pmw(ea);
      // Only this sequence reads tables, so the latch is never clobbered
      tlast <= last;
      tlo <= p[7:0];
      thi <= p[10:8];
      tstart <= 1'b1;
      @(negedge clk);
      tstart <= 1'b0;
      check({15'h0, pmr}, 16'h0001);
      check({5'h00, pma}, {5'h00, ea});
      @(negedge clk);
      check({15'h0, tdone}, 16'h0001);
      check(tword, ew);
      latch_exp = int'(ew[15:8]);
      @(negedge clk);
      rd_c(`TBL_HIGH_OFS);
      wr_b(`TBL_HIGH_OFS, ~ew[15:8]);
      rd_c(`TBL_HIGH_OFS);
   endtask

   task automatic icp_word(input logic [15:0] w, input int n);
      for (int i = 15; i >= 0; i--)
      begin
         pdi <= w[i];
         repeat (4) @(negedge clk);
         pck <= 1'b1;
         repeat (4) @(negedge clk);
         pck <= 1'b0;
      end
      repeat (6) @(negedge clk);
      check(16'(dq.size()), 16'h0001);
      if (dq.size() > 0)
      begin
         check(dq.pop_front(), w);
         check({5'h00, aq.pop_front()}, 16'(n));
      end
      check({15'h0, oe}, 16'h0000);
      check({15'h0, dout}, 16'h0000);
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (6) @(negedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      for (int a = 1; a < 5; a++)
         rd_c(8'(a));
      $display("Test reset values done");
      // Fill offsets 5 to 255 of each bank in turn, then read all 256 offsets back
      for (int b = 0; b < 2; b++)
      begin
         wr_b(`BANK_SEL_OFS, 8'(b));
         for (int a = 5; a < 256; a++)
         begin
            rnd = lfsr(rnd);
            wr_b(8'(a), rnd[7:0]);
         end
         for (int a = 0; a < 256; a++)
            rd_c(8'(a));
      end
      check({8'h00, nvm}, 16'(nvmc));
      $display("Test direct map done");
      wr_b(`PTR_FIRST_OFS, 8'h90);
      wr_b(`IND_FIRST_OFS, 8'ha5);
      rd_c(8'h90);
      wr_b(`BANK_SEL_OFS, 8'h00);
      rd_c(8'h90);
      wr_b(`PTR_FIRST_OFS, `IND_SECOND_OFS);
      wr_b(`IND_FIRST_OFS, 8'h5a);
      rd_c(`IND_FIRST_OFS);
      wr_b(`PTR_SECOND_OFS, `IND_FIRST_OFS);
      rd_c(`IND_SECOND_OFS);
      for (int i = 0; i < 150; i++)
      begin
         rnd = lfsr(rnd);
         case (rnd[2:0])
            3'h0: wr_b(`PTR_FIRST_OFS, rnd[15:8]);
            3'h1: wr_b(`PTR_SECOND_OFS, rnd[15:8]);
            3'h2: wr_b(`BANK_SEL_OFS, rnd[15:8]);
            3'h3: wr_b(`IND_FIRST_OFS, rnd[15:8]);
            3'h4: wr_b(`IND_SECOND_OFS, rnd[15:8]);
            3'h5: rd_c(`IND_FIRST_OFS);
            3'h6: rd_c(`IND_SECOND_OFS);
            default: rd_c(rnd[15:8]);
         endcase
      end
      $display("Test indirect done");
      tbl_c(1'b1, 11'h006);
      tbl_c(1'b0, 11'h2c5);
      for (int i = 0; i < 6; i++)
      begin
         rnd = lfsr(rnd);
         tbl_c(rnd[0], rnd[15:5]);
      end
      $display("Test table read done");
      pmode <= 1'b1;
      rnd = lfsr(rnd);
      icp_word(rnd, 0);
      icp_word(~rnd, 1);
      pmode <= 1'b0;
      repeat (2) @(negedge clk);
      check({5'h00, icpa}, 16'h0000);
      $display("Test serial programming done");
      stop_test();
   end

   // A hang costs a mismatch; normal run is about 2700 cycles
   initial
   begin
      #(20000 * 25);
      fails++;
      stop_test();
   end
endmodule // testbench

`default_nettype wire
